// *** ident_pkg.sv ***
// Constants for the identify parameter words 80 to 85
// Function
// - Word 80 reports major versions 2 to 5
// - Word 80 high, obsolete, reserved bits zero
// - Word 81 returns fixed minor version code
// - Word 82 sets supported command set bits
// - Word 82 absent features and reserved read zero
// - Word 83 fixed pattern plus feature claims
// - Word 84 fixed pattern plus SMART logging
// - Word 85 shipping value, look-ahead in bit 6
// - Word 85 bit 5 follows write cache
// - Word 85 bit 1 follows security mode
// - Word 85 bit 0 follows SMART enable
// - Identify: busy, fill buffer, data request, interrupt
// - Every reserved bit or word reads zero
package ident_pkg;
  localparam logic [15:0] WORD80_VAL      = 16'h003C;
  localparam logic [15:0] WORD81_VAL      = 16'h0013;
  localparam logic [15:0] WORD82_VAL      = 16'h746B;
  localparam logic [15:0] WORD83_VAL      = 16'h5988;
  localparam logic [15:0] WORD84_VAL      = 16'h4003;
  localparam logic [15:0] WORD85_SHIP     = 16'h7468;
  localparam logic [15:0] WORD85_LIVE_MSK = 16'h0063;
  localparam int          LOOKAHEAD_BIT   = 6;
  localparam int          WCACHE_BIT      = 5;
  localparam int          SECURITY_BIT    = 1;
  localparam int          SMART_BIT       = 0;
  localparam logic [6:0]  FIRST_INDEX     = 7'h50;
  localparam int          WORD_COUNT      = 6;
  localparam logic        LOOKAHEAD_RST   = 1'b1;
  localparam logic        WCACHE_RST      = 1'b1;
  localparam logic        SECURITY_RST    = 1'b0;
  localparam logic        SMART_RST       = 1'b0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILL = 2'b01,
    ST_DRQ  = 2'b11
  } serve_state_t;
endpackage : ident_pkg

// *** ident_word_rom.sv ***
// Word builder: maps a word index to its identify value
`timescale 1ns/1ps
module ident_word_rom
  import ident_pkg::*;
(
  input  wire logic [2:0]  sel_i,
  input  wire logic        lookahead_i,
  input  wire logic        wcache_i,
  input  wire logic        security_i,
  input  wire logic        smart_i,
  output logic      [15:0] word_o
);
  logic [15:0] live;

  always_comb begin
    live                = WORD85_SHIP & ~WORD85_LIVE_MSK;
    live[LOOKAHEAD_BIT] = lookahead_i;
    live[WCACHE_BIT]    = wcache_i;
    live[SECURITY_BIT]  = security_i;
    live[SMART_BIT]     = smart_i;
    case (sel_i)
      3'h0:    word_o = WORD80_VAL;
      3'h1:    word_o = WORD81_VAL;
      3'h2:    word_o = WORD82_VAL;
      3'h3:    word_o = WORD83_VAL;
      3'h4:    word_o = WORD84_VAL;
      3'h5:    word_o = live;
      default: word_o = 16'h0000;
    endcase
  end
endmodule : ident_word_rom

// *** ident_words.sv ***
// Identify words 80 to 85: feature state, snapshot buffer and read-out
`timescale 1ns/1ps
module ident_words
  import ident_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        identify_i,
  input  wire logic        lookahead_en_i,
  input  wire logic        lookahead_dis_i,
  input  wire logic        wcache_en_i,
  input  wire logic        wcache_dis_i,
  input  wire logic        security_set_i,
  input  wire logic        security_clr_i,
  input  wire logic        smart_en_i,
  input  wire logic        smart_dis_i,
  input  wire logic        status_read_i,
  input  wire logic        data_read_i,
  output logic             busy_o,
  output logic             drq_o,
  output logic             intrq_o,
  output logic      [15:0] data_o,
  output logic      [2:0]  index_o
);
  // ----------------------------------------------------------------
  // Live feature state
  // ----------------------------------------------------------------
  logic lookahead, wcache, security, smart;
  logic next_lookahead, next_wcache, next_security, next_smart;

  // Enable wins if both arrive together, so a fresh enable is not lost
  always_comb begin
    next_lookahead = lookahead;
    next_wcache    = wcache;
    next_security  = security;
    next_smart     = smart;
    if (lookahead_dis_i) next_lookahead = 1'b0;
    if (lookahead_en_i)  next_lookahead = 1'b1;
    if (wcache_dis_i)    next_wcache    = 1'b0;
    if (wcache_en_i)     next_wcache    = 1'b1;
    if (security_clr_i)  next_security  = 1'b0;
    if (security_set_i)  next_security  = 1'b1;
    if (smart_dis_i)     next_smart     = 1'b0;
    if (smart_en_i)      next_smart     = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lookahead <= LOOKAHEAD_RST;
      wcache    <= WCACHE_RST;
      security  <= SECURITY_RST;
      smart     <= SMART_RST;
    end else begin
      lookahead <= next_lookahead;
      wcache    <= next_wcache;
      security  <= next_security;
      smart     <= next_smart;
    end
  end

  // ----------------------------------------------------------------
  // Sector buffer fill and host read-out
  // ----------------------------------------------------------------
  // Snapshot keeps the words stable while the host reads, even if
  // a feature command lands mid-transfer.
  logic [15:0]  buffer [WORD_COUNT];
  logic [15:0]  rom_word;
  logic [2:0]   ptr, next_ptr;
  serve_state_t state, next_state;
  logic         next_busy, next_drq, next_intrq;
  logic [15:0]  next_data;

  // Pointer helpers shared by the fill and read-out paths
  function automatic logic last_word(input logic [2:0] p);
    return p == 3'(WORD_COUNT - 1);
  endfunction : last_word

  function automatic logic [2:0] step_ptr(input logic [2:0] p);
    return p + 3'h1;
  endfunction : step_ptr

  ident_word_rom u_rom (
    .sel_i       (ptr),
    .lookahead_i (lookahead),
    .wcache_i    (wcache),
    .security_i  (security),
    .smart_i     (smart),
    .word_o      (rom_word)
  );

  always_comb begin
    next_state = state;
    next_ptr   = ptr;
    next_busy  = busy_o;
    next_drq   = drq_o;
    next_intrq = intrq_o;
    next_data  = data_o;
    case (state)
      ST_IDLE: begin
        if (identify_i) begin
          next_state = ST_FILL;
          next_ptr   = 3'h0;
          next_busy  = 1'b1;
        end
      end
      ST_FILL: begin
        if (last_word(ptr)) begin
          next_state = ST_DRQ;
          next_ptr   = 3'h0;
          next_busy  = 1'b0;
          next_drq   = 1'b1;
          next_intrq = 1'b1;
          next_data  = buffer[0];
        end else begin
          next_ptr = step_ptr(ptr);
        end
      end
      ST_DRQ: begin
        if (status_read_i) next_intrq = 1'b0;
        if (data_read_i) begin
          if (last_word(ptr)) begin
            next_state = ST_IDLE;
            next_drq   = 1'b0;
            next_ptr   = 3'h0;
            next_data  = 16'h0000;
          end else begin
            next_ptr  = step_ptr(ptr);
            next_data = buffer[step_ptr(ptr)];
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_ptr   = 3'h0;
        next_busy  = 1'b0;
        next_drq   = 1'b0;
        next_intrq = 1'b0;
        next_data  = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state   <= ST_IDLE;
      ptr     <= 3'h0;
      busy_o  <= 1'b0;
      drq_o   <= 1'b0;
      intrq_o <= 1'b0;
      data_o  <= 16'h0000;
      index_o <= 3'h0;
    end else begin
      state   <= next_state;
      ptr     <= next_ptr;
      busy_o  <= next_busy;
      drq_o   <= next_drq;
      intrq_o <= next_intrq;
      data_o  <= next_data;
      index_o <= next_ptr;
    end
  end

  // Buffer has no reset; it is always filled before it is read
  always_ff @(posedge clk_i) begin
    if (state == ST_FILL) buffer[ptr] <= rom_word;
  end
endmodule : ident_words

// *** ident_words_properties.sv ***
// Checker for identify words 80 to 85
`timescale 1ns/1ps
module ident_words_properties (
  input wire logic        clk_i, rstn_i, identify_i, status_read_i, data_read_i, busy_o, drq_o, intrq_o,
  input wire logic [15:0] data_o,
  input wire logic [2:0]  index_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  AST_TAKE: assert property (identify_i && !busy_o && !drq_o |=> busy_o) else $error("take");
  AST_FILL: assert property ($rose(busy_o) |-> busy_o[*6] ##1 (drq_o && intrq_o && !busy_o)) else $error("fill");
  AST_W80: assert property ($rose(drq_o) |-> data_o == 16'h003C && index_o == 3'h0) else $error("w80");
  AST_W81: assert property (drq_o && index_o == 3'h1 |-> data_o == 16'h0013) else $error("w81");
  AST_W82: assert property (drq_o && index_o == 3'h2 |-> data_o == 16'h746B) else $error("w82");
  AST_W83: assert property (drq_o && index_o == 3'h3 |-> data_o == 16'h5988) else $error("w83");
  AST_W84: assert property (drq_o && index_o == 3'h4 |-> data_o == 16'h4003) else $error("w84");
  AST_IDLE0: assert property (!drq_o |-> data_o == 16'h0000) else $error("idle data");
  AST_W85: assert property (drq_o && index_o == 3'h5 |-> (data_o & 16'hFF9C) == 16'h7408) else $error("w85");
  AST_LAST: assert property (drq_o && data_read_i && index_o == 3'h5 |=> !drq_o && data_o == 16'h0) else $error("end");
  AST_IRQ: assert property (drq_o && status_read_i |=> !intrq_o) else $error("irq");
  cover property ($rose(drq_o));
  cover property (drq_o && data_read_i && index_o == 3'h5);
  cover property (identify_i && busy_o);
endmodule : ident_words_properties
bind ident_words ident_words_properties u_props (.clk_i, .rstn_i, .identify_i, .status_read_i, .data_read_i,
  .busy_o, .drq_o, .intrq_o, .data_o, .index_o);

// *** host_reader.sv ***
// Host model: reads status, then the six identify words
`timescale 1ns/1ps
module host_reader (
  input  wire logic        clk_i, intrq_i,
  input  wire logic [15:0] data_i,
  input  wire logic [1:0]  gap_i,
  output logic             status_read_o, data_read_o,
  output logic      [15:0] got_o [6]
);
  // Gap of zero holds the read strobe up so words go back to back
  initial begin
    status_read_o = 1'b0;
    data_read_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (intrq_i === 1'b1) begin
        #1 status_read_o = 1'b1;
        @(posedge clk_i);
        #1 status_read_o = 1'b0;
        for (int k = 0; k < 6; k++) begin
          data_read_o = 1'b1;
          @(posedge clk_i);
          got_o[k] = data_i;
          #1 if (gap_i != 2'h0 || k == 5) data_read_o = 1'b0;
          repeat (gap_i) @(posedge clk_i);
          if (gap_i != 2'h0) #1;
        end
      end
    end
  end
endmodule : host_reader

// *** tb_top.sv ***
// Testbench for identify words 80 to 85
`timescale 1ns/1ps
module tb_top;
  logic        clk_i, rstn_i, identify_i, busy_o, drq_o, intrq_o, status_read_i, data_read_i;
  logic [7:0]  feat;
  logic [1:0]  gap;
  logic [2:0]  index_o;
  logic [15:0] data_o;
  logic [15:0] got [6];
  int          fails, n_checks;
  ident_words dut (.clk_i, .rstn_i, .identify_i, .lookahead_en_i(feat[7]), .lookahead_dis_i(feat[6]),
    .wcache_en_i(feat[5]), .wcache_dis_i(feat[4]), .security_set_i(feat[3]), .security_clr_i(feat[2]),
    .smart_en_i(feat[1]), .smart_dis_i(feat[0]), .status_read_i, .data_read_i, .busy_o, .drq_o,
    .intrq_o, .data_o, .index_o);
  host_reader host (.clk_i, .intrq_i(intrq_o), .data_i(data_o), .gap_i(gap),
    .status_read_o(status_read_i), .data_read_o(data_read_i), .got_o(got));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task chk(input logic [95:0] g, input logic [95:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task test_done;
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // Feature pulse, then identify; a second identify mid-fill must be dropped
  task run_id(input logic [7:0] f, input logic [1:0] g, input logic [15:0] w85);
    feat = f;
    gap = g;
    @(posedge clk_i);
    #1 feat = 8'h00;
    identify_i = 1'b1;
    @(posedge clk_i);
    #1 identify_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 identify_i = 1'b1;
    @(posedge clk_i);
    #1 identify_i = 1'b0;
    for (int i = 0; i < 20 && drq_o !== 1'b1; i++) @(posedge clk_i);
    for (int i = 0; i < 80 && drq_o === 1'b1; i++) @(posedge clk_i);
    #1;
    chk({got[0], got[1], got[2], got[3], got[4], got[5]}, {80'h003C_0013_746B_5988_4003, w85});
    chk({93'h0, busy_o, drq_o, intrq_o}, 96'h0);
    for (int i = 2; i < 6; i++) chk({95'h0, got[i] == 16'h0000 || got[i] == 16'hFFFF}, 96'h0);
  endtask : run_id
  task t_ship; run_id(8'h00, 2'h0, 16'h7468); endtask : t_ship
  // Look-ahead and cache off, security and SMART on, slow host
  task t_change; run_id(8'h5A, 2'h2, 16'h740B); endtask : t_change
  // Look-ahead and cache enable and disable together: enable wins; security and SMART cleared
  task t_collide; run_id(8'hF5, 2'h0, 16'h7468); endtask : t_collide
  initial begin
    rstn_i = 1'b0;
    identify_i = 1'b0;
    feat = 8'h00;
    gap = 2'h0;
    repeat (5) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    t_ship;
    t_change;
    t_collide;
    test_done;
  end
  initial begin
    #20000;
    fails++;
    test_done;
  end
endmodule : tb_top
